// file: design/pds_top.sv
/*
 * Pump duty sequencer top: Avalon-MM register slave, two setpoint slots,
 * lead rotation and relay selection for the four duty modes.
 * Assumes LEVEL_IN is driven by level logic on REF_CLK_IN.
 */
// Functional notes
// - Duty mode selects the relay control algorithm
// - Alternate assist lets both pumps run together
// - Fixed assist lets both pumps run together
// - Backup modes never energise more than one relay
// - First pump starts at its on setpoint
// - Second pump stops at its off setpoint
// - Alternate modes start with pump one leading
// - Alternate modes rotate on setpoint each cycle
// - Off setpoints rotate together with on setpoints
// - Fixed modes never rotate pump order
// - Backup new pump replaces running one
`timescale 1ns/1ps
module pds_top (
    // Clock and reset
    input  wire logic                        REF_CLK_IN,
    input  wire logic                        SYS_RST_IN,
    // Measured level
    input  wire logic [pds_pkg::LVL_W-1:0]   LEVEL_IN,
    // Avalon-MM slave
    input  wire logic [pds_pkg::ADDR_W-1:0]  AVS_ADDRESS_IN,
    input  wire logic                        AVS_READ_IN,
    input  wire logic                        AVS_WRITE_IN,
    input  wire logic [pds_pkg::DATA_W-1:0]  AVS_WRITEDATA_IN,
    input  wire logic [pds_pkg::BE_W-1:0]    AVS_BYTEENABLE_IN,
    output logic      [pds_pkg::DATA_W-1:0]  AVS_READDATA_OUT,
    output logic                             AVS_WAITREQUEST_OUT,
    // Pump relays
    output logic      [pds_pkg::NPUMP-1:0]   PUMP_RELAY_OUT
);
    import pds_pkg::*;

    // ==========================================================
    // Byte-lane merge for the 16-bit setpoint registers
    function automatic logic [LVL_W-1:0] be_merge(input logic [LVL_W-1:0]  old_v,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [BE_W-1:0]   be);
        logic [LVL_W-1:0] v;
        v = old_v;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    // ==========================================================
    // Register and bus state
    logic [CTRL_MODE_W-1:0] mode_r,    mode_nxt;
    logic                   en_r,      en_nxt;
    logic [LVL_W-1:0]       on1_r,     on1_nxt;
    logic [LVL_W-1:0]       off1_r,    off1_nxt;
    logic [LVL_W-1:0]       on2_r,     on2_nxt;
    logic [LVL_W-1:0]       off2_r,    off2_nxt;
    logic                   wait_r,    wait_nxt;
    logic [DATA_W-1:0]      rdata_r,   rdata_nxt;
    logic                   req;
    logic                   commit_wr;

    // Pump state
    logic [NPUMP-1:0]       relay_r,   relay_nxt;
    logic                   lead_r,    lead_nxt;
    logic                   dem0;
    logic                   dem1;
    logic [LVL_W-1:0]       slot0_on,  slot0_off;
    logic [LVL_W-1:0]       slot1_on,  slot1_off;
    pds_mode_t              mode;
    logic                   alt_mode;
    logic                   backup_mode;

    assign req       = AVS_READ_IN | AVS_WRITE_IN;
    // A write lands only on the edge at which the master sees waitrequest low
    assign commit_wr = AVS_WRITE_IN & ~wait_r;

    // ==========================================================
    // Register bus: one wait state, then one-cycle acknowledge
    always_comb begin
        mode_nxt  = mode_r;
        en_nxt    = en_r;
        on1_nxt   = on1_r;
        off1_nxt  = off1_r;
        on2_nxt   = on2_r;
        off2_nxt  = off2_r;
        wait_nxt  = ~(req & wait_r);
        rdata_nxt = rdata_r;
        if (commit_wr) begin
            case (AVS_ADDRESS_IN)
                REG_CTRL: begin
                    if (AVS_BYTEENABLE_IN[0]) begin
                        mode_nxt = AVS_WRITEDATA_IN[CTRL_MODE_LSB +: CTRL_MODE_W];
                        en_nxt   = AVS_WRITEDATA_IN[CTRL_EN_BIT];
                    end
                end
                REG_ON_SP1:  on1_nxt  = be_merge(on1_r,  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                REG_OFF_SP1: off1_nxt = be_merge(off1_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                REG_ON_SP2:  on2_nxt  = be_merge(on2_r,  AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                REG_OFF_SP2: off2_nxt = be_merge(off2_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                default: begin
                end
            endcase
        end
        if (AVS_READ_IN & wait_r) begin
            rdata_nxt = RST_RDATA;
            case (AVS_ADDRESS_IN)
                REG_CTRL: begin
                    rdata_nxt[CTRL_MODE_LSB +: CTRL_MODE_W] = mode_r;
                    rdata_nxt[CTRL_EN_BIT]                  = en_r;
                end
                REG_ON_SP1:  rdata_nxt[LVL_W-1:0] = on1_r;
                REG_OFF_SP1: rdata_nxt[LVL_W-1:0] = off1_r;
                REG_ON_SP2:  rdata_nxt[LVL_W-1:0] = on2_r;
                REG_OFF_SP2: rdata_nxt[LVL_W-1:0] = off2_r;
                REG_LEVEL:   rdata_nxt[LVL_W-1:0] = LEVEL_IN;
                REG_STATUS: begin
                    rdata_nxt[NPUMP-1:0]    = relay_r;
                    rdata_nxt[STAT_LEAD_BIT] = lead_r;
                    rdata_nxt[STAT_DEM_LSB +: NPUMP] = {dem1, dem0};
                end
                default: rdata_nxt = RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_r  <= MODE_ALT_ASSIST;
            en_r    <= 1'b0;
            on1_r   <= RST_ON_SP;
            off1_r  <= RST_OFF_SP;
            on2_r   <= RST_ON_SP;
            off2_r  <= RST_OFF_SP;
            wait_r  <= 1'b1;
            rdata_r <= RST_RDATA;
        end else begin
            mode_r  <= mode_nxt;
            en_r    <= en_nxt;
            on1_r   <= on1_nxt;
            off1_r  <= off1_nxt;
            on2_r   <= on2_nxt;
            off2_r  <= off2_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Setpoint slots: slot 0 holds the first setpoints, slot 1 the next
    assign mode        = pds_mode_t'(mode_r);
    assign alt_mode    = (mode == MODE_ALT_ASSIST) | (mode == MODE_ALT_BACKUP);
    assign backup_mode = (mode == MODE_ALT_BACKUP) | (mode == MODE_FIX_BACKUP);
    assign slot0_on    = on1_r;
    assign slot0_off   = off1_r;
    assign slot1_on    = on2_r;
    assign slot1_off   = off2_r;
    // Slots are tied to setpoint pairs, pumps are picked by lead_r,
    // so off setpoints always travel with their on setpoints.

    pds_slot u_slot0 (
        .clk_in     (REF_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .level_in   (LEVEL_IN),
        .on_sp_in   (slot0_on),
        .off_sp_in  (slot0_off),
        .demand_out (dem0)
    );

    pds_slot u_slot1 (
        .clk_in     (REF_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .level_in   (LEVEL_IN),
        .on_sp_in   (slot1_on),
        .off_sp_in  (slot1_off),
        .demand_out (dem1)
    );

    // ==========================================================
    // Relay selection and lead rotation
    always_comb begin
        relay_nxt = '0;
        lead_nxt  = lead_r;
        if (en_r) begin
            if (backup_mode) begin
                // Slot 1 demand wins over slot 0 and drops the pump already running
                if (dem1) begin
                    relay_nxt[~lead_r] = 1'b1;
                end else if (dem0) begin
                    relay_nxt[lead_r] = 1'b1;
                end
            end else begin
                relay_nxt[lead_r]  = dem0;
                relay_nxt[~lead_r] = dem1;
            end
        end
        // A cycle ends when every relay drops; in alternate modes only then may the lead move
        if (alt_mode && (relay_r != '0) && (relay_nxt == '0)) begin
            lead_nxt = ~lead_r;
        end
        if (!alt_mode) begin
            lead_nxt = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            relay_r <= '0;
            lead_r  <= 1'b0;
        end else begin
            relay_r <= relay_nxt;
            lead_r  <= lead_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign PUMP_RELAY_OUT      = relay_r;
    assign AVS_READDATA_OUT    = rdata_r;
    assign AVS_WAITREQUEST_OUT = wait_r;
endmodule

// file: design/pds_pkg.sv
/*
 * Shared constants and types for the pump duty sequencer: register map,
 * field layout, reset values and the duty mode enumeration.
 * Assumes a 32-bit Avalon-MM register bus and a 16-bit level code.
 */
package pds_pkg;
    // ==========================================================
    // Widths
    localparam int LVL_W  = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int BE_W   = 4;
    localparam int NPUMP  = 2;

    // ==========================================================
    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL    = 5'h00;
    localparam logic [ADDR_W-1:0] REG_ON_SP1  = 5'h04;
    localparam logic [ADDR_W-1:0] REG_OFF_SP1 = 5'h08;
    localparam logic [ADDR_W-1:0] REG_ON_SP2  = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_OFF_SP2 = 5'h10;
    localparam logic [ADDR_W-1:0] REG_LEVEL   = 5'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h18;

    // ==========================================================
    // Control and status fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W   = 2;
    localparam int CTRL_EN_BIT   = 2;
    localparam int STAT_LEAD_BIT = 2;
    localparam int STAT_DEM_LSB  = 3;

    // ==========================================================
    // Reset values
    localparam logic [LVL_W-1:0]  RST_ON_SP   = 16'hFFFF;
    localparam logic [LVL_W-1:0]  RST_OFF_SP  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_RDATA   = 32'h0000_0000;

    // ==========================================================
    // Duty modes, in the order of their CTRL code
    typedef enum logic [CTRL_MODE_W-1:0] {
        MODE_ALT_ASSIST,
        MODE_ALT_BACKUP,
        MODE_FIX_ASSIST,
        MODE_FIX_BACKUP
    } pds_mode_t;
endpackage

// file: design/pds_slot.sv
/*
 * One setpoint slot: holds pump demand with hysteresis for pump-down use.
 * Assumes the level comes from logic on the same clock.
 */
`timescale 1ns/1ps
module pds_slot (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // Level and setpoints
    input  wire logic [pds_pkg::LVL_W-1:0] level_in,
    input  wire logic [pds_pkg::LVL_W-1:0] on_sp_in,
    input  wire logic [pds_pkg::LVL_W-1:0] off_sp_in,
    // Demand
    output logic                       demand_out
);
    import pds_pkg::*;

    logic demand_r;
    logic demand_nxt;

    // ==========================================================
    // Hysteresis: on at or above on setpoint, off at or below off
    always_comb begin
        demand_nxt = demand_r;
        if (level_in <= off_sp_in) begin
            demand_nxt = 1'b0;
        end
        // Set wins if setpoints overlap, so a high level is never ignored
        if (level_in >= on_sp_in) begin
            demand_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            demand_r <= 1'b0;
        end else begin
            demand_r <= demand_nxt;
        end
    end

    assign demand_out = demand_r;
endmodule

// file: verification/pds_sva.sv
/* Checker for pds_top: bus handshake, readback and relay rules.
   Sees only the top ports; mode and enable are mirrored from CTRL writes. */
`timescale 1ns/1ps
module pds_sva (
    // Clock and reset
    input wire logic                        REF_CLK_IN,
    input wire logic                        SYS_RST_IN,
    // Level and bus
    input wire logic [pds_pkg::LVL_W-1:0]   LEVEL_IN,
    input wire logic [pds_pkg::ADDR_W-1:0]  AVS_ADDRESS_IN,
    input wire logic                        AVS_READ_IN,
    input wire logic                        AVS_WRITE_IN,
    input wire logic [pds_pkg::DATA_W-1:0]  AVS_WRITEDATA_IN,
    input wire logic [pds_pkg::BE_W-1:0]    AVS_BYTEENABLE_IN,
    input wire logic [pds_pkg::DATA_W-1:0]  AVS_READDATA_OUT,
    input wire logic                        AVS_WAITREQUEST_OUT,
    // Relays
    input wire logic [pds_pkg::NPUMP-1:0]   PUMP_RELAY_OUT
);
    import pds_pkg::*;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // ==========================================================
    // Mode mirror
    logic bk_r;
    logic en_r;
    logic bk_nxt;
    logic en_nxt;
    logic ctrl_wr;
    always_comb begin
        ctrl_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == REG_CTRL && AVS_BYTEENABLE_IN[0];
        bk_nxt  = ctrl_wr ? AVS_WRITEDATA_IN[0] : bk_r;
        en_nxt  = ctrl_wr ? AVS_WRITEDATA_IN[CTRL_EN_BIT] : en_r;
    end
    always_ff @(posedge REF_CLK_IN) begin
        bk_r <= SYS_RST_IN ? 1'b0 : bk_nxt;
        en_r <= SYS_RST_IN ? 1'b0 : en_nxt;
    end
    // ==========================================================
    // Assertions
    sequence s_req;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_rd_ack;
        AVS_READ_IN && !AVS_WAITREQUEST_OUT;
    endsequence
    // Writes can move setpoints, so a quiet window excludes them
    sequence s_quiet;
        (!AVS_WRITE_IN && $stable(LEVEL_IN)) [*3];
    endsequence
    a_wait_answer: assert property (s_req |=> !AVS_WAITREQUEST_OUT)
        else $error("waitrequest not low after one wait state");
    a_wait_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property ($fell(AVS_WAITREQUEST_OUT) |-> $past(AVS_READ_IN) || $past(AVS_WRITE_IN))
        else $error("waitrequest dropped without a request");
    a_unmapped_zero: assert property (s_rd_ack ##0 AVS_ADDRESS_IN > REG_STATUS |-> AVS_READDATA_OUT == '0)
        else $error("unmapped read not zero");
    a_level_read: assert property (s_rd_ack ##0 AVS_ADDRESS_IN == REG_LEVEL |->
        AVS_READDATA_OUT == {16'h0000, $past(LEVEL_IN)})
        else $error("level register does not show level input");
    a_off_disabled: assert property (!en_r && !$past(en_r) |-> PUMP_RELAY_OUT == '0)
        else $error("relay on while disabled");
    a_backup_single: assert property (bk_r && $past(bk_r) |-> $countones(PUMP_RELAY_OUT) <= 1)
        else $error("two relays on in backup mode");
    a_relay_settle: assert property (s_quiet |=> $stable(PUMP_RELAY_OUT))
        else $error("relay changed with level held");
    c_both_on: cover property (PUMP_RELAY_OUT == 2'b11);
endmodule

bind pds_top pds_sva chk_u (.*);

// file: verification/pds_tank.sv
/* Wet well model: level rises with inflow and falls per energised pump.
   Assumes one clock; load forces a level for stepped tests. */
`timescale 1ns/1ps
module pds_tank (
    // Clock
    input  wire logic                        clk_in,
    // Forced level
    input  wire logic                        load_in,
    input  wire logic [pds_pkg::LVL_W-1:0]   load_lvl_in,
    // Relays and level
    input  wire logic [pds_pkg::NPUMP-1:0]   relay_in,
    output logic      [pds_pkg::LVL_W-1:0]   level_out
);
    import pds_pkg::*;
    // One pump rises slowly, two drain, so assist reaches both on points
    localparam logic [LVL_W-1:0] INFLOW  = 16'h0003;
    localparam logic [LVL_W-1:0] OUTFLOW = 16'h0002;
    logic [LVL_W-1:0] level_r;
    logic [LVL_W-1:0] level_nxt;
    assign level_out = load_in ? load_lvl_in : level_r;
    always_comb begin
        level_nxt = level_out + INFLOW - (relay_in[0] ? OUTFLOW : '0) - (relay_in[1] ? OUTFLOW : '0);
    end
    always_ff @(posedge clk_in) begin
        level_r <= level_nxt;
    end
endmodule

// file: verification/pds_top_test.sv
/* Bench for pds_top: register access, four duty modes stepped and
   alternate assist free running. Assumes the pds_tank model drives the level. */
`timescale 1ns/1ps
module pds_top_test;
    import pds_pkg::*;
    logic clk, rst, rd, wr, load, wreq;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] wd, rdata, r;
    logic [BE_W-1:0] be;
    logic [LVL_W-1:0] lvl, ld_lvl;
    logic [NPUMP-1:0] relay, relay_q;
    logic [DATA_W-1:0] rq[$];
    logic [NPUMP-1:0] pq[$];
    logic [DATA_W-1:0] rst_exp[8] = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0, 32'h20, 32'h0, 32'h0};
    logic [DATA_W-1:0] sp[4] = '{32'h40, 32'h10, 32'h48, 32'h10};
    int err_count = 0;
    int n_checks = 0;
    int lead = 0;
    pds_top dut_u (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .LEVEL_IN(lvl), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq), .PUMP_RELAY_OUT(relay));
    pds_tank tank_u (.clk_in(clk), .load_in(load), .load_lvl_in(ld_lvl), .relay_in(relay), .level_out(lvl));
    // ==========================================================
    // Compare and closing
    task results();
        err_count += pq.size() + rq.size();
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task cmp_rd(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] a);
        n_checks++;
        if (a !== e) begin
            err_count++;
            $display("unexpected read at %0t: exp %h got %h", $time, e, a);
        end
    endtask
    task cmp_relay(input logic [NPUMP-1:0] e, input logic [NPUMP-1:0] a);
        n_checks++;
        if (a !== e) begin
            err_count++;
            $display("unexpected relay at %0t: exp %h got %h", $time, e, a);
        end
    endtask
    // Oldest note is taken whenever read data or a relay change appears
    always @(posedge clk) begin
        if (!rst && rd && wreq === 1'b0) begin
            cmp_rd(rq.size() > 0 ? rq.pop_front() : ~rdata, rdata);
        end
        if (!rst && relay !== relay_q) begin
            cmp_relay(pq.size() > 0 ? pq.pop_front() : relay_q, relay);
        end
        relay_q <= relay;
    end
    // ==========================================================
    // Drivers
    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [BE_W-1:0] e);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= e;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (wreq !== 1'b0) begin
            err_count++;
            results();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rdx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task step(input logic [LVL_W-1:0] v);
        @(posedge clk);
        load <= 1'b1;
        ld_lvl <= v;
        repeat (4) @(posedge clk);
    endtask
    // One pumping cycle: on point 1, on point 2, common off point
    task cyc(input int m, input logic free);
        logic [NPUMP-1:0] p0;
        int n;
        p0 = (lead != 0 && m < 2) ? 2'b10 : 2'b01;
        pq.push_back(p0);
        pq.push_back(m[0] ? ~p0 : 2'b11);
        pq.push_back(2'b00);
        if (m < 2) lead = 1 - lead;
        if (free) begin
            @(posedge clk);
            load <= 1'b0;
            n = 0;
            while (pq.size() > 0 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            if (pq.size() > 0) begin
                err_count++;
                results();
            end
            step(16'h0010);
        end else begin
            step(16'h0040);
            step(16'h0048);
            step(16'h0010);
        end
    endtask
    // ==========================================================
    // Sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    initial begin
        rst = 1'b1;
        {rd, wr, adr, wd, be, relay_q} = '0;
        load = 1'b1;
        ld_lvl = 16'h0020;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h6F0DC3FC));
        foreach (rst_exp[i]) rdx(ADDR_W'(i * 4), rst_exp[i]);
        bus(1'b1, REG_CTRL, 32'h7, 4'h0);
        rdx(REG_CTRL, 32'h0);
        r = $urandom();
        bus(1'b1, REG_ON_SP2, r, 4'h3);
        rdx(REG_ON_SP2, {16'h0000, r[15:0]});
        bus(1'b1, REG_LEVEL, r, 4'hF);
        rdx(REG_LEVEL, 32'h20);
        foreach (sp[i]) bus(1'b1, ADDR_W'(4 + i * 4), sp[i], 4'hF);
        // A low random on point may have latched slot demand; drain it first
        step(16'h0010);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, REG_CTRL, 32'(4 + m), 4'hF);
            rdx(REG_CTRL, 32'(4 + m));
            cyc(m, 1'b0);
            cyc(m, 1'b0);
        end
        bus(1'b1, REG_CTRL, 32'h4, 4'hF);
        cyc(0, 1'b1);
        cyc(0, 1'b1);
        rdx(REG_STATUS, 32'h0);
        bus(1'b1, REG_CTRL, 32'h0, 4'hF);
        step(16'h0040);
        step(16'h0048);
        step(16'h0010);
        results();
    end
endmodule
